// ===== src/clk_ts_pkg.sv
// Constants shared by the clock select, time stamp and calibration block.
// Assumes a 250 MHz system clock and a 32-bit classic Wishbone register bus.
package clk_ts_pkg;
   localparam int SYS_CLK_MHZ = 250;
   localparam int ADR_W = 8;
   localparam int NUM_PINS = 4;
   localparam int PIN_SEL_W = 2;

   // Register byte offsets.
   localparam logic [ADR_W-1:0] CLK_CFG_OFS = 8'h00;
   localparam logic [ADR_W-1:0] LF_TRIM_OFS = 8'h04;
   localparam logic [ADR_W-1:0] HF_TRIM_OFS = 8'h08;
   localparam logic [ADR_W-1:0] STAMP_CTL_OFS = 8'h0c;
   localparam logic [ADR_W-1:0] STAMP_INTERVAL_OFS = 8'h10;
   localparam logic [ADR_W-1:0] SLOT_DELTA_OFS = 8'h14;
   localparam logic [ADR_W-1:0] HF_CAL_CTL_OFS = 8'h18;
   localparam logic [ADR_W-1:0] HF_CAL_RESULT_OFS = 8'h1c;

   // Clock configuration fields.
   localparam int RATE_BIT = 0;
   localparam int FAST_EN_BIT = 1;
   localparam int SLOW_EN_BIT = 2;
   localparam int MODE_LSB = 3;
   localparam int MODE_W = 2;
   localparam int EXT_SEL_LSB = 8;
   localparam int RUN_BIT = 16;

   // Trim fields.
   localparam int SLOW_TRIM_LSB = 0;
   localparam int SLOW_TRIM_W = 6;
   localparam int FAST_TRIM_LSB = 16;
   localparam int FAST_TRIM_W = 10;
   localparam int HF_TRIM_LSB = 0;
   localparam int HF_TRIM_W = 8;

   // Time stamp control fields.
   localparam int ARM_BIT = 0;
   localparam int REARM_BIT = 1;
   localparam int INVERT_BIT = 2;
   localparam int STAMP_SEL_LSB = 8;

   localparam int CAL_TRIGGER_BIT = 0;
   localparam int STAMP_W = 32;
   localparam int HF_CAL_W = 16;

   // Clock source modes.
   localparam logic [MODE_W-1:0] MODE_INTERNAL = 2'h0;
   localparam logic [MODE_W-1:0] MODE_EXT_LF = 2'h1;
   localparam logic [MODE_W-1:0] MODE_EXT_HF = 2'h2;
   localparam logic [MODE_W-1:0] MODE_EXT_BOTH = 2'h3;

   // Division of the external 32 MHz clock and calibration windows.
   localparam int DIV_W = 10;
   localparam logic [DIV_W-1:0] DIV_TO_32K = 10'd1000;
   localparam logic [DIV_W-1:0] DIV_TO_1M = 10'd32;
   localparam int CAL_LF_W = 8;
   localparam logic [CAL_LF_W-1:0] CAL_CYC_1M = 8'd128;
   localparam logic [CAL_LF_W-1:0] CAL_CYC_32K = 8'd32;

   // Settling time of the 32 MHz oscillator before counting starts.
   localparam int HF_SETTLE_NS = 10000;
   localparam int HF_SETTLE_CYC = (HF_SETTLE_NS * SYS_CLK_MHZ + 999) / 1000;
   localparam int SETTLE_W = 12;

   typedef enum logic [1:0] {
      CAL_IDLE = 2'b00,
      CAL_SETTLE = 2'b01,
      CAL_ALIGN = 2'b10,
      CAL_COUNT = 2'b11
   } cal_state_t;
endpackage : clk_ts_pkg

// ===== src/pin_sync.sv
// Three-stage synchroniser with edge pulses for one asynchronous input.
// Assumes the input may change at any time relative to sys_clk_i.
`timescale 1ns/1ps
module pin_sync (
   input wire logic sys_clk_i,
   input wire logic rst_b_i,
   input wire logic pin_i,
   output logic level_o,
   output logic rise_o,
   output logic fall_o
);
   logic meta_r;
   logic sync_r;
   logic late_r;

   // A change counts only once the second and third stages agree.
   always_ff @(posedge sys_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         meta_r <= 1'b0;
         sync_r <= 1'b0;
         late_r <= 1'b0;
         level_o <= 1'b0;
         rise_o <= 1'b0;
         fall_o <= 1'b0;
      end
      else
      begin
         meta_r <= pin_i;
         sync_r <= meta_r;
         late_r <= sync_r;
         rise_o <= (sync_r == late_r) && late_r && !level_o;
         fall_o <= (sync_r == late_r) && !late_r && level_o;
         if (sync_r == late_r)
         begin
            level_o <= late_r;
         end
      end
   end
endmodule : pin_sync

// ===== src/clock_select_timestamp_calibration.sv
// Clock source selection, time stamp capture and 32 MHz oscillator calibration.
// Assumes oscillator outputs and pins arrive asynchronously and the slot sequencer shares sys_clk_i.
`timescale 1ns/1ps
// Contract
// - Rate bit picks internal 32 kHz when 0, 1 MHz when 1.
// - Each internal low frequency oscillator runs only while its enable bit is 1.
// - 6-bit trim for the 32 kHz oscillator, 10-bit trim for 1 MHz.
// - Mode 1 takes the low frequency base straight from the chosen pin.
// - Mode 2 takes only the fast clock from the pin; mode 3 both.
// - Mode 3 divides the external 32 MHz by 32 or 1000 per rate bit.
// - Modes 0 and 1 power the internal 32 MHz only for wake-up, active slots or calibration.
// - External clocks come from the pin named by the clock pin select field.
// - The 32 MHz clock drives the high speed slot timing machine.
// - A counter of low frequency cycles measures spacing between stamp triggers.
// - Each capture records low frequency cycles left to the next slot start.
// - Setting the arm bit arms capture on the stamp pin's next active edge.
// - Capture clears the arm bit unless automatic re-arm is set.
// - Triggers fire on rising edges, or falling edges when invert is set.
// - Interval counting works whenever the low frequency clock runs, even outside go.
// - Calibration trigger powers the 32 MHz oscillator in modes 0 and 1 and waits for it to settle.
// - Count 32 MHz cycles over 128 fast or 32 slow low frequency cycles.
// - Afterwards power down unless wake-up or active slots need it, and clear the trigger bit in the same cycle.
// - With an external low frequency clock, calibration counts against that clock.
// - A trim field adjusts the 32 MHz oscillator frequency.
// - Run bit 0 to 1 starts slots; writing 0 stops and resets them.
module clock_select_timestamp_calibration (
   input wire logic sys_clk_i,
   input wire logic rst_b_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [clk_ts_pkg::ADR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic [clk_ts_pkg::NUM_PINS-1:0] gpio_i,
   input wire logic osc_slow_lf_i,
   input wire logic osc_fast_lf_i,
   input wire logic osc_hf_i,
   input wire logic wake_window_i,
   input wire logic slots_active_i,
   input wire logic [clk_ts_pkg::STAMP_W-1:0] slot_countdown_i,
   output logic slow_lf_osc_enable_o,
   output logic fast_lf_osc_enable_o,
   output logic hf_osc_enable_o,
   output logic [clk_ts_pkg::SLOW_TRIM_W-1:0] slow_lf_trim_o,
   output logic [clk_ts_pkg::FAST_TRIM_W-1:0] fast_lf_trim_o,
   output logic [clk_ts_pkg::HF_TRIM_W-1:0] hf_osc_trim_o,
   output logic lf_tick_o,
   output logic hf_tick_o,
   output logic run_mode_o,
   output logic go_start_o
);
   import clk_ts_pkg::*;

   localparam int NUM_SRC = NUM_PINS + 3;

   // Configuration state.
   logic lf_clock_rate_select_r;
   logic fast_lf_osc_enable_r;
   logic slow_lf_osc_enable_r;
   logic [MODE_W-1:0] clock_source_mode_r;
   logic [PIN_SEL_W-1:0] ext_clock_pin_select_r;
   logic run_mode_ctl_r;
   logic stamp_capture_arm_r;
   logic stamp_capture_arm_nxt;
   logic stamp_rearm_auto_r;
   logic stamp_edge_invert_r;
   logic [PIN_SEL_W-1:0] stamp_pin_select_r;
   logic hf_cal_trigger_r;
   logic [HF_CAL_W-1:0] hf_cal_result_r;

   // Time stamp state.
   logic [STAMP_W-1:0] stamp_cnt_r;
   logic [STAMP_W-1:0] stamp_interval_cycles_r;
   logic [STAMP_W-1:0] cycles_to_next_slot_r;

   // Clock generation and calibration state.
   logic [DIV_W-1:0] div_cnt_r;
   logic div_tick_r;
   cal_state_t cal_state_r;
   cal_state_t cal_state_nxt;
   logic [SETTLE_W-1:0] settle_cnt_r;
   logic [CAL_LF_W-1:0] cal_lf_cnt_r;
   logic [HF_CAL_W-1:0] cal_hf_cnt_r;

   // Synchronised oscillator and pin inputs.
   logic [NUM_SRC-1:0] src_raw;
   logic [NUM_SRC-1:0] src_rise;
   logic [NUM_SRC-1:0] src_fall;
   logic [NUM_PINS-1:0] pin_rise;
   logic [NUM_PINS-1:0] pin_fall;

   assign src_raw = {osc_hf_i, osc_fast_lf_i, osc_slow_lf_i, gpio_i};
   assign pin_rise = src_rise[NUM_PINS-1:0];
   assign pin_fall = src_fall[NUM_PINS-1:0];

   genvar gi;
   generate
      for (gi = 0; gi < NUM_SRC; gi++)
      begin : g_sync
         pin_sync u_sync (
            .sys_clk_i(sys_clk_i),
            .rst_b_i(rst_b_i),
            .pin_i(src_raw[gi]),
            .level_o(),
            .rise_o(src_rise[gi]),
            .fall_o(src_fall[gi])
         );
      end
   endgenerate

   wire slow_osc_rise = src_rise[NUM_PINS];
   wire fast_osc_rise = src_rise[NUM_PINS+1];
   wire hf_osc_rise = src_rise[NUM_PINS+2];

   // Clock source selection.
   wire ext_clk_rise = pin_rise[ext_clock_pin_select_r];
   wire int_lf_tick = lf_clock_rate_select_r ? (fast_osc_rise && fast_lf_osc_enable_r)
                                             : (slow_osc_rise && slow_lf_osc_enable_r);
   wire mode_ext_lf = (clock_source_mode_r == MODE_EXT_LF);
   wire mode_ext_both = (clock_source_mode_r == MODE_EXT_BOTH);
   wire hf_internal = (clock_source_mode_r == MODE_INTERNAL) || mode_ext_lf;
   wire lf_tick = mode_ext_lf ? ext_clk_rise : (mode_ext_both ? div_tick_r : int_lf_tick);
   wire hf_tick = hf_internal ? (hf_osc_rise && hf_osc_enable_o) : ext_clk_rise;
   wire lf_running = mode_ext_lf || mode_ext_both ||
                     (lf_clock_rate_select_r ? fast_lf_osc_enable_r : slow_lf_osc_enable_r);
   wire [DIV_W-1:0] div_limit = lf_clock_rate_select_r ? DIV_TO_1M : DIV_TO_32K;
   wire div_wrap = (div_cnt_r == div_limit - 1'b1);

   // Bus decode.
   wire bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   wire bus_wr = bus_req && wb_we_i;
   wire wr_clk_cfg = bus_wr && (wb_adr_i == CLK_CFG_OFS);
   wire wr_lf_trim = bus_wr && (wb_adr_i == LF_TRIM_OFS);
   wire wr_hf_trim = bus_wr && (wb_adr_i == HF_TRIM_OFS);
   wire wr_stamp_ctl = bus_wr && (wb_adr_i == STAMP_CTL_OFS);
   wire wr_cal_ctl = bus_wr && (wb_adr_i == HF_CAL_CTL_OFS);
   wire [31:0] byte_mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

   // Read-back words, each field shifted to its position.
   wire [31:0] clk_cfg_rd = (32'(lf_clock_rate_select_r) << RATE_BIT) | (32'(fast_lf_osc_enable_r) << FAST_EN_BIT)
      | (32'(slow_lf_osc_enable_r) << SLOW_EN_BIT) | (32'(clock_source_mode_r) << MODE_LSB)
      | (32'(ext_clock_pin_select_r) << EXT_SEL_LSB) | (32'(run_mode_ctl_r) << RUN_BIT);
   wire [31:0] lf_trim_rd = (32'(slow_lf_trim_o) << SLOW_TRIM_LSB) | (32'(fast_lf_trim_o) << FAST_TRIM_LSB);
   wire [31:0] hf_trim_rd = 32'(hf_osc_trim_o) << HF_TRIM_LSB;
   wire [31:0] stamp_ctl_rd = (32'(stamp_capture_arm_r) << ARM_BIT) | (32'(stamp_rearm_auto_r) << REARM_BIT)
      | (32'(stamp_edge_invert_r) << INVERT_BIT) | (32'(stamp_pin_select_r) << STAMP_SEL_LSB);
   wire [31:0] cal_ctl_rd = 32'(hf_cal_trigger_r) << CAL_TRIGGER_BIT;
   wire [31:0] cal_result_rd = 32'(hf_cal_result_r);
   logic [31:0] rd_mux;

   always_comb
   begin
      case (wb_adr_i)
         CLK_CFG_OFS: rd_mux = clk_cfg_rd;
         LF_TRIM_OFS: rd_mux = lf_trim_rd;
         HF_TRIM_OFS: rd_mux = hf_trim_rd;
         STAMP_CTL_OFS: rd_mux = stamp_ctl_rd;
         STAMP_INTERVAL_OFS: rd_mux = stamp_interval_cycles_r;
         SLOT_DELTA_OFS: rd_mux = cycles_to_next_slot_r;
         HF_CAL_CTL_OFS: rd_mux = cal_ctl_rd;
         HF_CAL_RESULT_OFS: rd_mux = cal_result_rd;
         default: rd_mux = 32'h0;
      endcase
   end

   // Merged words hold the written bytes over the current contents.
   wire [31:0] clk_cfg_wr = (clk_cfg_rd & ~byte_mask) | (wb_dat_i & byte_mask);
   wire [31:0] lf_trim_wr = (lf_trim_rd & ~byte_mask) | (wb_dat_i & byte_mask);
   wire [31:0] hf_trim_wr = (hf_trim_rd & ~byte_mask) | (wb_dat_i & byte_mask);
   wire [31:0] stamp_ctl_wr = (stamp_ctl_rd & ~byte_mask) | (wb_dat_i & byte_mask);
   wire [31:0] cal_ctl_wr = (cal_ctl_rd & ~byte_mask) | (wb_dat_i & byte_mask);

   always_ff @(posedge sys_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0;
      end
      else
      begin
         wb_ack_o <= bus_req;
         wb_dat_o <= bus_req ? rd_mux : 32'h0;
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         lf_clock_rate_select_r <= 1'b0;
         fast_lf_osc_enable_r <= 1'b0;
         slow_lf_osc_enable_r <= 1'b0;
         clock_source_mode_r <= MODE_INTERNAL;
         ext_clock_pin_select_r <= '0;
         run_mode_ctl_r <= 1'b0;
      end
      else if (wr_clk_cfg)
      begin
         lf_clock_rate_select_r <= clk_cfg_wr[RATE_BIT];
         fast_lf_osc_enable_r <= clk_cfg_wr[FAST_EN_BIT];
         slow_lf_osc_enable_r <= clk_cfg_wr[SLOW_EN_BIT];
         clock_source_mode_r <= clk_cfg_wr[MODE_LSB +: MODE_W];
         ext_clock_pin_select_r <= clk_cfg_wr[EXT_SEL_LSB +: PIN_SEL_W];
         run_mode_ctl_r <= clk_cfg_wr[RUN_BIT];
      end
   end

   // Clock outputs, trims, run control and the mode 3 divider.
   always_ff @(posedge sys_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         div_cnt_r <= '0;
         div_tick_r <= 1'b0;
         lf_tick_o <= 1'b0;
         hf_tick_o <= 1'b0;
         run_mode_o <= 1'b0;
         go_start_o <= 1'b0;
         hf_osc_enable_o <= 1'b0;
         slow_lf_osc_enable_o <= 1'b0;
         fast_lf_osc_enable_o <= 1'b0;
         slow_lf_trim_o <= '0;
         fast_lf_trim_o <= '0;
         hf_osc_trim_o <= '0;
      end
      else
      begin
         if (!mode_ext_both)
         begin
            div_cnt_r <= '0;
         end
         else if (ext_clk_rise)
         begin
            div_cnt_r <= div_wrap ? '0 : div_cnt_r + 1'b1;
         end
         div_tick_r <= mode_ext_both && ext_clk_rise && div_wrap;
         lf_tick_o <= lf_tick;
         hf_tick_o <= hf_tick;
         run_mode_o <= run_mode_ctl_r;
         go_start_o <= run_mode_ctl_r && !run_mode_o;
         hf_osc_enable_o <= hf_internal &&
                            (wake_window_i || slots_active_i || (cal_state_nxt != CAL_IDLE));
         slow_lf_osc_enable_o <= slow_lf_osc_enable_r;
         fast_lf_osc_enable_o <= fast_lf_osc_enable_r;
         if (wr_lf_trim)
         begin
            slow_lf_trim_o <= lf_trim_wr[SLOW_TRIM_LSB +: SLOW_TRIM_W];
            fast_lf_trim_o <= lf_trim_wr[FAST_TRIM_LSB +: FAST_TRIM_W];
         end
         if (wr_hf_trim)
         begin
            hf_osc_trim_o <= hf_trim_wr[HF_TRIM_LSB +: HF_TRIM_W];
         end
      end
   end

   // Time stamp capture.
   wire stamp_edge = stamp_edge_invert_r ? pin_fall[stamp_pin_select_r]
                                         : pin_rise[stamp_pin_select_r];
   wire stamp_capture = stamp_capture_arm_r && stamp_edge;

   // A software write to the arm bit wins over the clear by a capture.
   assign stamp_capture_arm_nxt = wr_stamp_ctl ? stamp_ctl_wr[ARM_BIT]
                                : ((stamp_capture && !stamp_rearm_auto_r) ? 1'b0 : stamp_capture_arm_r);

   always_ff @(posedge sys_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         stamp_capture_arm_r <= 1'b0;
         stamp_rearm_auto_r <= 1'b0;
         stamp_edge_invert_r <= 1'b0;
         stamp_pin_select_r <= '0;
         stamp_cnt_r <= '0;
         stamp_interval_cycles_r <= '0;
         cycles_to_next_slot_r <= '0;
      end
      else
      begin
         stamp_capture_arm_r <= stamp_capture_arm_nxt;
         if (wr_stamp_ctl)
         begin
            stamp_rearm_auto_r <= stamp_ctl_wr[REARM_BIT];
            stamp_edge_invert_r <= stamp_ctl_wr[INVERT_BIT];
            stamp_pin_select_r <= stamp_ctl_wr[STAMP_SEL_LSB +: PIN_SEL_W];
         end
         if (stamp_capture)
         begin
            stamp_interval_cycles_r <= stamp_cnt_r;
            cycles_to_next_slot_r <= slot_countdown_i;
            stamp_cnt_r <= '0;
         end
         else if (lf_running && lf_tick && !(&stamp_cnt_r))
         begin
            stamp_cnt_r <= stamp_cnt_r + 1'b1;
         end
      end
   end

   // Calibration of the 32 MHz oscillator.
   wire cal_start = wr_cal_ctl && cal_ctl_wr[CAL_TRIGGER_BIT] && (cal_state_r == CAL_IDLE);
   wire [CAL_LF_W-1:0] cal_window = lf_clock_rate_select_r ? CAL_CYC_1M : CAL_CYC_32K;
   wire settle_done = (settle_cnt_r == SETTLE_W'(HF_SETTLE_CYC - 1));
   wire cal_last = lf_tick && (cal_lf_cnt_r == cal_window - 1'b1);
   wire [HF_CAL_W-1:0] cal_hf_inc = cal_hf_cnt_r + HF_CAL_W'(hf_tick && !(&cal_hf_cnt_r));

   always_comb
   begin
      cal_state_nxt = cal_state_r;
      case (cal_state_r)
         CAL_IDLE: if (cal_start) cal_state_nxt = CAL_SETTLE;
         CAL_SETTLE: if (settle_done) cal_state_nxt = CAL_ALIGN;
         CAL_ALIGN: if (lf_tick) cal_state_nxt = CAL_COUNT;
         CAL_COUNT: if (cal_last) cal_state_nxt = CAL_IDLE;
         default: cal_state_nxt = CAL_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         cal_state_r <= CAL_IDLE;
         settle_cnt_r <= '0;
         cal_lf_cnt_r <= '0;
         cal_hf_cnt_r <= '0;
         hf_cal_trigger_r <= 1'b0;
         hf_cal_result_r <= '0;
      end
      else
      begin
         cal_state_r <= cal_state_nxt;
         settle_cnt_r <= (cal_state_r == CAL_SETTLE) ? settle_cnt_r + 1'b1 : '0;
         if (cal_start)
         begin
            hf_cal_trigger_r <= 1'b1;
         end
         else if ((cal_state_r == CAL_COUNT) && cal_last)
         begin
            hf_cal_trigger_r <= 1'b0;
         end
         if (cal_state_r != CAL_COUNT)
         begin
            cal_lf_cnt_r <= '0;
            cal_hf_cnt_r <= '0;
         end
         else
         begin
            cal_hf_cnt_r <= cal_hf_inc;
            if (lf_tick)
            begin
               cal_lf_cnt_r <= cal_lf_cnt_r + 1'b1;
            end
            if (cal_last)
            begin
               hf_cal_result_r <= cal_hf_inc;
            end
         end
      end
   end
endmodule : clock_select_timestamp_calibration

// ===== bench/clk_ts_asserts.sv
// Port level checks for the clock select, time stamp and calibration block.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
module clk_ts_checker (
   input wire logic sys_clk_i,
   input wire logic rst_b_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [clk_ts_pkg::ADR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic slow_lf_osc_enable_o,
   input wire logic fast_lf_osc_enable_o,
   input wire logic [clk_ts_pkg::SLOW_TRIM_W-1:0] slow_lf_trim_o,
   input wire logic [clk_ts_pkg::FAST_TRIM_W-1:0] fast_lf_trim_o,
   input wire logic [clk_ts_pkg::HF_TRIM_W-1:0] hf_osc_trim_o,
   input wire logic lf_tick_o,
   input wire logic hf_tick_o,
   input wire logic run_mode_o,
   input wire logic go_start_o
);
   import clk_ts_pkg::*;
   logic [31:0] dat_q;
   wire wr_ack = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && (wb_sel_i == 4'hf);
   always_ff @(posedge sys_clk_i or negedge rst_b_i)
      if (!rst_b_i)
         dat_q <= 32'h0;
      else if (wr_ack)
         dat_q <= wb_dat_i;
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (!rst_b_i);
   a_ack_follows_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack missing one cycle after request");
   a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");
   a_dat_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
      else $error("read data not zero outside ack");
   a_cfg_copy: assert property (wr_ack && wb_adr_i == CLK_CFG_OFS |-> ##2
      fast_lf_osc_enable_o == dat_q[FAST_EN_BIT] && slow_lf_osc_enable_o == dat_q[SLOW_EN_BIT]
      && run_mode_o == dat_q[RUN_BIT]) else $error("clock config outputs do not follow write");
   a_lf_trim_copy: assert property (wr_ack && wb_adr_i == LF_TRIM_OFS |-> ##2
      slow_lf_trim_o == dat_q[SLOW_TRIM_LSB +: SLOW_TRIM_W] && fast_lf_trim_o == dat_q[FAST_TRIM_LSB +: FAST_TRIM_W])
      else $error("low frequency trims do not follow write");
   a_hf_trim_copy: assert property (wr_ack && wb_adr_i == HF_TRIM_OFS |-> ##2
      hf_osc_trim_o == dat_q[HF_TRIM_LSB +: HF_TRIM_W]) else $error("fast trim does not follow write");
   a_go_on_rise: assert property ($rose(run_mode_o) |-> ##[0:1] go_start_o)
      else $error("no start pulse on run rise");
   a_go_cause: assert property (go_start_o |-> run_mode_o ##1 !go_start_o)
      else $error("start pulse without run or too long");
   a_lf_tick_pulse: assert property (lf_tick_o |=> !lf_tick_o)
      else $error("low frequency tick longer than one cycle");
   a_hf_tick_pulse: assert property (hf_tick_o |=> !hf_tick_o)
      else $error("fast tick longer than one cycle");
endmodule : clk_ts_checker
bind clock_select_timestamp_calibration clk_ts_checker i_clk_ts_checker (
   .sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
   .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .slow_lf_osc_enable_o(slow_lf_osc_enable_o), .fast_lf_osc_enable_o(fast_lf_osc_enable_o),
   .slow_lf_trim_o(slow_lf_trim_o), .fast_lf_trim_o(fast_lf_trim_o), .hf_osc_trim_o(hf_osc_trim_o),
   .lf_tick_o(lf_tick_o), .hf_tick_o(hf_tick_o), .run_mode_o(run_mode_o), .go_start_o(go_start_o));

// ===== bench/osc_model.sv
// Oscillators and the external 32 MHz pin clock seen by the block.
// Assumes shortened low frequency periods so calibration windows stay brief.
`timescale 1ns/1ps
module osc_model #(
   parameter int SLOW_HALF = 200,
   parameter int FAST_HALF = 40,
   parameter int HF_HALF = 16
) (
   input wire logic slow_en_i,
   input wire logic fast_en_i,
   input wire logic hf_en_i,
   output logic slow_o,
   output logic fast_o,
   output logic hf_o,
   output logic ext_hf_o
);
   // A disabled oscillator holds its level; odd phases keep edges off the sampling clock.
   initial
   begin
      slow_o = 1'b0;
      #1.1;
      forever #(SLOW_HALF) if (slow_en_i) slow_o = !slow_o;
   end
   initial
   begin
      fast_o = 1'b0;
      #1.3;
      forever #(FAST_HALF) if (fast_en_i) fast_o = !fast_o;
   end
   initial
   begin
      hf_o = 1'b0;
      #1.7;
      forever #(HF_HALF) if (hf_en_i) hf_o = !hf_o;
   end
   initial
   begin
      ext_hf_o = 1'b0;
      #0.9;
      forever #(HF_HALF) ext_hf_o = !ext_hf_o;
   end
endmodule : osc_model

// ===== bench/test_clock_select_timestamp_calibration.sv
// Self-checking bench for clock selection, time stamp capture and calibration.
// Assumes the oscillator model beside it and a classic Wishbone master here.
`timescale 1ns/1ps
module test_clock_select_timestamp_calibration;
   import clk_ts_pkg::*;
   logic clk, rst_b, cyc, stb, we, ack, pin, slow_en, fast_en, hf_en, slow, fast, hf, ext, lf_tick, run, act;
   logic [ADR_W-1:0] adr;
   logic [3:0] sel;
   logic [31:0] dat_w, dat_r, cd, q;
   logic [SLOW_TRIM_W-1:0] s_trim;
   logic [FAST_TRIM_W-1:0] f_trim;
   logic [HF_TRIM_W-1:0] h_trim;
   int miscompares = 0;
   int comparisons = 0;
   clock_select_timestamp_calibration i_clock_select_timestamp_calibration (
      .sys_clk_i(clk), .rst_b_i(rst_b), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(dat_r), .wb_ack_o(ack), .gpio_i({ext, 2'b00, pin}),
      .osc_slow_lf_i(slow), .osc_fast_lf_i(fast), .osc_hf_i(hf), .wake_window_i(act), .slots_active_i(act),
      .slot_countdown_i(cd), .slow_lf_osc_enable_o(slow_en), .fast_lf_osc_enable_o(fast_en),
      .hf_osc_enable_o(hf_en), .slow_lf_trim_o(s_trim), .fast_lf_trim_o(f_trim), .hf_osc_trim_o(h_trim),
      .lf_tick_o(lf_tick), .hf_tick_o(), .run_mode_o(run), .go_start_o());
   osc_model i_osc_model (.slow_en_i(slow_en), .fast_en_i(fast_en), .hf_en_i(hf_en),
      .slow_o(slow), .fast_o(fast), .hf_o(hf), .ext_hf_o(ext));
   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   task automatic report_and_stop();
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : report_and_stop
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         miscompares++;
         $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic rng(input logic [31:0] got, input int lo, input int hi);
      comparisons++;
      if ((got >= lo && got <= hi) !== 1'b1)
      begin
         miscompares++;
         $display("CHECK FAILED %0t got %0d outside %0d to %0d", $time, got, lo, hi);
      end
   endtask : rng
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
      @(posedge clk);
      {cyc, stb, we, adr, dat_w, sel} <= {2'b11, w, a, d, 4'hf};
      do
         @(posedge clk);
      while (ack !== 1'b1);
      r = dat_r;
      {cyc, stb, we} <= 3'b000;
   endtask : xfer
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      xfer(1'b1, a, d, r);
      repeat (2) @(posedge clk);
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] r);
      xfer(1'b0, a, 32'h0, r);
   endtask : rd
   function automatic logic [31:0] cfg(input logic r, input logic fe, input logic se, input logic [1:0] m,
      input logic [1:0] p, input logic ru);
      return (32'(r) << RATE_BIT) | (32'(fe) << FAST_EN_BIT) | (32'(se) << SLOW_EN_BIT) | (32'(m) << MODE_LSB)
         | (32'(p) << EXT_SEL_LSB) | (32'(ru) << RUN_BIT);
   endfunction : cfg
   task automatic ticks(input logic [31:0] c, input int lo, input int hi);
      int n;
      n = 0;
      wr(CLK_CFG_OFS, c);
      repeat (100) @(posedge clk);
      repeat (800)
      begin
         @(posedge clk);
         n += (lf_tick === 1'b1) ? 1 : 0;
      end
      rng(32'(n), lo, hi);
   endtask : ticks
   task automatic tog(input int n);
      @(posedge clk);
      pin <= !pin;
      repeat (n) @(posedge clk);
   endtask : tog
   task automatic cal(input int lo, input int hi);
      logic [31:0] r;
      wr(HF_CAL_CTL_OFS, 32'h1);
      rd(HF_CAL_CTL_OFS, r);
      chk(r, 32'h1);
      chk(32'(hf_en), 32'h1);
      wr(HF_CAL_CTL_OFS, 32'h1);
      do
         rd(HF_CAL_CTL_OFS, r);
      while (r[0] !== 1'b0);
      repeat (3) @(posedge clk);
      chk(32'(hf_en), 32'h0);
      rd(HF_CAL_RESULT_OFS, r);
      rng(r, lo, hi);
   endtask : cal
   initial
   begin
      {rst_b, cyc, stb, we, pin, act, adr, sel, dat_w, cd} = '0;
      repeat (3) @(posedge clk);
      rst_b <= 1'b1;
      rd(CLK_CFG_OFS, q);
      chk(q, 32'h0);
      rd(8'h40, q);
      chk(q, 32'h0);
      wr(LF_TRIM_OFS, 32'hffff_ffff);
      rd(LF_TRIM_OFS, q);
      chk(q, 32'h03ff_003f);
      chk({s_trim, f_trim}, 16'hffff);
      wr(HF_TRIM_OFS, 32'ha5);
      chk(32'(h_trim), 32'ha5);
      wr(CLK_CFG_OFS, cfg(1, 1, 0, MODE_INTERNAL, 0, 1));
      chk(32'(run), 32'h1);
      ticks(cfg(0, 0, 1, MODE_INTERNAL, 0, 0), 7, 9);
      ticks(cfg(1, 0, 1, MODE_INTERNAL, 0, 0), 0, 0);
      ticks(cfg(1, 1, 0, MODE_EXT_LF, 3, 0), 98, 102);
      ticks(cfg(1, 1, 0, MODE_EXT_LF, 2, 0), 0, 0);
      ticks(cfg(1, 0, 0, MODE_EXT_BOTH, 3, 0), 2, 4);
      ticks(cfg(1, 1, 0, MODE_EXT_HF, 3, 0), 38, 42);
      chk(32'(hf_en), 32'h0);
      ticks(cfg(1, 1, 0, MODE_INTERNAL, 0, 0), 38, 42);
      cal(318, 322);
      cd <= 32'h1234;
      wr(STAMP_CTL_OFS, 32'h3);
      repeat (3) tog(250);
      rd(STAMP_INTERVAL_OFS, q);
      rng(q, 24, 26);
      rd(STAMP_CTL_OFS, q);
      chk(q, 32'h3);
      rd(SLOT_DELTA_OFS, q);
      chk(q, 32'h1234);
      wr(STAMP_CTL_OFS, 32'h5);
      tog(250);
      rd(STAMP_CTL_OFS, q);
      chk(q, 32'h4);
      repeat (2) tog(250);
      rd(STAMP_INTERVAL_OFS, q);
      rng(q, 11, 14);
      // Stop the internal source first so the switch cannot merge two ticks.
      wr(CLK_CFG_OFS, cfg(1, 0, 0, MODE_INTERNAL, 0, 0));
      ticks(cfg(1, 1, 0, MODE_EXT_LF, 3, 0), 98, 102);
      cal(126, 130);
      act <= 1'b1;
      repeat (3) @(posedge clk);
      chk(32'(hf_en), 32'h1);
      report_and_stop();
   end
   initial
   begin
      repeat (40000) @(posedge clk);
      miscompares++;
      report_and_stop();
   end
endmodule : test_clock_select_timestamp_calibration
